/* File: shared/dhr_pkg.sv */
// constants shared by the debug-header reset merge and scan isolation glue
package dhr_pkg;

  // ----------------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SYNC_STAGES   = 2;

  // ----------------------------------------------------------------------
  // values after reset (active-low resets held asserted)
  // ----------------------------------------------------------------------
  localparam logic RST_HARD_N   = 1'h0;
  localparam logic RST_SOFT_N   = 1'h0;
  localparam logic RST_SCAN_N   = 1'h0;
  localparam logic RST_PRES_N   = 1'h1;
  localparam logic RST_ISO_EN   = 1'h0;
  localparam logic RST_ISOLATED = 1'h0;
  localparam logic RST_TDI      = 1'h1;
  localparam logic RST_TMS      = 1'h1;
  localparam logic RST_TDO      = 1'h1;

  // ----------------------------------------------------------------------
  // scan-chain routing modes
  // ----------------------------------------------------------------------
  typedef enum logic {
    DHR_CHAIN_JOINED,
    DHR_CHAIN_SPLIT
  } dhr_chain_t;

endpackage

/* File: core/dhr_sync.sv */
// two-flop level synchroniser used by the debug-header glue
`timescale 1ns/100ps
module dhr_sync #(
  parameter int unsigned       WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // data
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule

/* File: core/dhr_top.sv */
// debug-header glue: merges probe and board resets, isolates the processor scan chain
`timescale 1ns/100ps
module dhr_top
  import dhr_pkg::*;
(
  // system clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // probe reset requests and presence (active low pins)
  input  wire logic i_probe_hard_reset_n,
  input  wire logic i_probe_soft_reset_n,
  input  wire logic i_probe_scan_reset_n,
  input  wire logic i_probe_present_n,
  // board reset sources (active low pins)
  input  wire logic i_board_hard_reset_n,
  input  wire logic i_board_soft_reset_n,
  input  wire logic i_board_scan_reset_n,
  // isolation enable strap (debug build only)
  input  wire logic i_debug_iso_en,
  // scan link, probe side
  input  wire logic i_tck,
  input  wire logic i_probe_tms,
  input  wire logic i_probe_tdi,
  output logic      o_probe_tdo,
  // scan link, processor debug port
  output logic      o_cpu_tms,
  output logic      o_cpu_tdi,
  input  wire logic i_cpu_tdo,
  // scan link, rest of board chain
  output logic      o_board_tms,
  output logic      o_board_tdi,
  input  wire logic i_board_tdo,
  // merged resets to the processor and scan logic
  output logic      o_hard_reset_n,
  output logic      o_soft_reset_n,
  output logic      o_scan_reset_n,
  // status
  output logic      o_isolated
);

  // ----------------------------------------------------------------------
  // pin synchronisers, system domain
  // ----------------------------------------------------------------------
  logic probe_hr_s;
  logic probe_sr_s;
  logic probe_tr_s;
  logic board_hr_s;
  logic board_sr_s;
  logic board_tr_s;
  logic present_n_s;
  logic iso_en_s;

  // resets park asserted until the pins have been seen
  dhr_sync #(
    .WIDTH   (6),
    .RST_VAL ({RST_HARD_N, RST_SOFT_N, RST_SCAN_N, RST_HARD_N, RST_SOFT_N, RST_SCAN_N})
  ) u_sync_rst (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_probe_hard_reset_n, i_probe_soft_reset_n, i_probe_scan_reset_n,
              i_board_hard_reset_n, i_board_soft_reset_n, i_board_scan_reset_n}),
    .o_q    ({probe_hr_s, probe_sr_s, probe_tr_s, board_hr_s, board_sr_s, board_tr_s})
  );

  dhr_sync #(
    .WIDTH   (2),
    .RST_VAL ({RST_PRES_N, RST_ISO_EN})
  ) u_sync_ctl (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_probe_present_n, i_debug_iso_en}),
    .o_q    ({present_n_s, iso_en_s})
  );

  // ----------------------------------------------------------------------
  // reset merging
  // ----------------------------------------------------------------------
  logic hard_nxt;
  logic soft_nxt;
  logic scan_nxt;

  // an and of active-low sources is a wired-or done safely in logic
  always_comb begin
    hard_nxt = probe_hr_s & board_hr_s;
    soft_nxt = probe_sr_s & board_sr_s;
    // a detached probe leaves its pin pulled low, so scan reset stays on
    scan_nxt = probe_tr_s & board_tr_s;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hard_reset_n <= RST_HARD_N;
    end else begin
      o_hard_reset_n <= hard_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_soft_reset_n <= RST_SOFT_N;
    end else begin
      o_soft_reset_n <= soft_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_scan_reset_n <= RST_SCAN_N;
    end else begin
      o_scan_reset_n <= scan_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // isolation decision, system domain
  // ----------------------------------------------------------------------
  logic iso_nxt;

  // relies on the probe driving its presence pin; a silent probe is never split
  assign iso_nxt = iso_en_s & ~present_n_s;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_isolated <= RST_ISOLATED;
    end else begin
      o_isolated <= iso_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // scan link domain
  // ----------------------------------------------------------------------
  logic       iso_t;
  dhr_chain_t chain_mode;

  // tck only runs while the probe works, so the split takes effect on its edges
  dhr_sync #(
    .WIDTH   (1),
    .RST_VAL (RST_ISOLATED)
  ) u_sync_iso (
    .i_clk  (i_tck),
    .i_rstn (i_rstn),
    .i_d    (o_isolated),
    .o_q    (iso_t)
  );

  assign chain_mode = iso_t ? DHR_CHAIN_SPLIT : DHR_CHAIN_JOINED;

  // tms fans out to every device; the board only idles when its tdi is high
  always_ff @(posedge i_tck or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cpu_tms   <= RST_TMS;
      o_board_tms <= RST_TMS;
    end else begin
      o_cpu_tms   <= i_probe_tms;
      o_board_tms <= i_probe_tms;
    end
  end

  // processor is first in the chain in both modes
  always_ff @(posedge i_tck or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cpu_tdi <= RST_TDI;
    end else begin
      o_cpu_tdi <= i_probe_tdi;
    end
  end

  // limitation: each hop is retimed on tck, adding one bit of pipeline
  always_ff @(posedge i_tck or negedge i_rstn) begin
    if (!i_rstn) begin
      o_board_tdi <= RST_TDI;
      o_probe_tdo <= RST_TDO;
    end else begin
      unique case (chain_mode)
        DHR_CHAIN_SPLIT: begin
          o_board_tdi <= 1'h1;
          o_probe_tdo <= i_cpu_tdo;
        end
        DHR_CHAIN_JOINED: begin
          o_board_tdi <= i_cpu_tdo;
          o_probe_tdo <= i_board_tdo;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions, system domain
  // ----------------------------------------------------------------------
  chk_hard_probe_req: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !probe_hr_s |=> !o_hard_reset_n
  ) else $error("probe hard reset request not passed to processor");

  chk_hard_board_src: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (!board_hr_s && probe_hr_s) |=> !o_hard_reset_n
  ) else $error("board hard reset lost while probe released");

  chk_hard_release_all: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (probe_hr_s && board_hr_s) [*2] |-> o_hard_reset_n
  ) else $error("hard reset held although every source released");

  chk_soft_merge_and: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    ##1 o_soft_reset_n == ($past(probe_sr_s) & $past(board_sr_s))
  ) else $error("soft reset not the merge of its sources");

  chk_scan_no_probe: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !probe_tr_s |=> !o_scan_reset_n
  ) else $error("scan reset released while probe pin low");

  chk_scan_board_src: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    $fell(board_tr_s) |=> !o_scan_reset_n
  ) else $error("board scan reset not merged");

  chk_iso_needs_both: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (!iso_en_s || present_n_s) |=> !o_isolated
  ) else $error("chain split outside debug setup or without probe");

  chk_iso_follows: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (iso_en_s && !present_n_s) |=> o_isolated
  ) else $error("chain not split with probe present and enable set");

  chk_scan_release_all: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (probe_tr_s && board_tr_s) |=> o_scan_reset_n
  ) else $error("scan reset held although every source released");

  chk_soft_probe_req: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !probe_sr_s |=> !o_soft_reset_n
  ) else $error("probe soft reset request not passed to processor");

  // ----------------------------------------------------------------------
  // assertions, scan link domain
  // ----------------------------------------------------------------------
  chk_board_tdi_idle: assert property (
    @(posedge i_tck) disable iff (!i_rstn)
    iso_t |=> o_board_tdi
  ) else $error("board test-data input not idle while split");

  chk_split_tdo_route: assert property (
    @(posedge i_tck) disable iff (!i_rstn)
    iso_t |=> (o_probe_tdo == $past(i_cpu_tdo))
  ) else $error("probe does not see processor output while split");

  chk_joined_route: assert property (
    @(posedge i_tck) disable iff (!i_rstn)
    !iso_t |=> (o_board_tdi == $past(i_cpu_tdo)) && (o_probe_tdo == $past(i_board_tdo))
  ) else $error("joined chain routing broken");

  // tms reaches both chains in either mode, so the board sees the same state walk
  chk_tms_fanout: assert property (
    @(posedge i_tck) disable iff (!i_rstn)
    ##1 (o_cpu_tms == $past(i_probe_tms)) && (o_board_tms == $past(i_probe_tms))
  ) else $error("mode select not passed to both chains");

  chk_cpu_tdi_pass: assert property (
    @(posedge i_tck) disable iff (!i_rstn)
    ##1 o_cpu_tdi == $past(i_probe_tdi)
  ) else $error("probe test data not passed to processor");

  // ----------------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------------
  cov_probe_hard: cover property (
    @(posedge i_clk) disable iff (!i_rstn)
    !probe_hr_s && board_hr_s ##1 !o_hard_reset_n
  );

  cov_board_hard: cover property (
    @(posedge i_clk) disable iff (!i_rstn)
    !board_hr_s && probe_hr_s ##1 !o_hard_reset_n
  );

  cov_split_chain: cover property (
    @(posedge i_tck) disable iff (!i_rstn)
    iso_t ##1 o_board_tdi
  );

  cov_scan_release: cover property (
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(o_scan_reset_n)
  );

  cov_no_probe_scan: cover property (
    @(posedge i_clk) disable iff (!i_rstn)
    present_n_s && !probe_tr_s ##1 !o_scan_reset_n
  );

endmodule

/* File: sim/dhr_far_model.sv */
// far-side model: debug probe on the scan link plus processor and board scan devices
`timescale 1ns/100ps
module dhr_far_model (
  // bench control
  input  wire logic i_run,
  input  wire logic i_attached,
  input  wire logic i_tms_bit,
  input  wire logic i_tdi_bit,
  // scan devices
  input  wire logic i_cpu_tdi,
  input  wire logic i_board_tdi,
  output logic      o_cpu_tdo,
  output logic      o_board_tdo,
  // probe pins
  output logic      o_tck,
  output logic      o_present_n,
  output logic      o_tms,
  output logic      o_tdi
);
  logic cpu_bit;
  logic board_bit;

  // the probe really drives presence, the split logic depends on it
  assign o_present_n = ~i_attached;

  // ----------------------------------------------------------------------
  // scan clock: runs only within frames, stands low between them
  // ----------------------------------------------------------------------
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_cpu_tdo = 1'b1;
    o_board_tdo = 1'b1;
    #7;
    forever begin
      #15;
      o_tck = (i_run | o_tck) ? ~o_tck : 1'b0;
    end
  end

  always @(posedge o_tck) begin
    cpu_bit   <= i_cpu_tdi;
    board_bit <= i_board_tdi;
  end

  // one-bit bypass devices launch on the falling edge
  always @(negedge o_tck) begin
    o_tms       <= i_tms_bit;
    o_tdi       <= i_tdi_bit;
    o_cpu_tdo   <= cpu_bit;
    o_board_tdo <= board_bit;
  end

  // released tdo lines must not keep a stale value
  always @(negedge i_run) begin
    o_cpu_tdo   <= ~o_cpu_tdo;
    o_board_tdo <= ~o_board_tdo;
  end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the debug-header reset merge and scan isolation glue
`timescale 1ns/100ps
module tb_top
  import dhr_pkg::*;
;
  logic clk, rstn, phr, psr, pscr, bhr, bsr, bscr, iso_en, run, att, tms_b, tdi_b;
  logic tck, pres_n, ptms, ptdi, ptdo, ctms, ctdi, ctdo, btms, btdi, btdo;
  logic hr, sr, scr, isol, s_tdi, s_tms, s_ctdo, s_btdo;
  logic [31:0] seed;
  int n_mismatch, tests_run, cycles, edges, edge0;

  dhr_top dut (.i_clk(clk), .i_rstn(rstn), .i_probe_hard_reset_n(phr),
    .i_probe_soft_reset_n(psr), .i_probe_scan_reset_n(pscr), .i_probe_present_n(pres_n),
    .i_board_hard_reset_n(bhr), .i_board_soft_reset_n(bsr), .i_board_scan_reset_n(bscr),
    .i_debug_iso_en(iso_en), .i_tck(tck), .i_probe_tms(ptms), .i_probe_tdi(ptdi),
    .o_probe_tdo(ptdo), .o_cpu_tms(ctms), .o_cpu_tdi(ctdi), .i_cpu_tdo(ctdo),
    .o_board_tms(btms), .o_board_tdi(btdi), .i_board_tdo(btdo), .o_hard_reset_n(hr),
    .o_soft_reset_n(sr), .o_scan_reset_n(scr), .o_isolated(isol));

  dhr_far_model far (.i_run(run), .i_attached(att), .i_tms_bit(tms_b), .i_tdi_bit(tdi_b),
    .i_cpu_tdi(ctdi), .i_board_tdi(btdi), .o_cpu_tdo(ctdo), .o_board_tdo(btdo),
    .o_tck(tck), .o_present_n(pres_n), .o_tms(ptms), .o_tdi(ptdi));

  always #12.5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scan path model: sample before each rising edge, compare at the fall
  // ----------------------------------------------------------------------
  always @(posedge tck) begin
    s_tdi  <= ptdi;
    s_tms  <= ptms;
    s_ctdo <= ctdo;
    s_btdo <= btdo;
    edges  <= edges + 1;
  end

  // routing may switch within 3 tck of a frame start, so early edges are skipped
  always @(negedge tck) begin
    if (run && (edges - edge0) > 4) begin
      check(ctdi, s_tdi);
      check(ctms, s_tms);
      check(btms, s_tms);
      if (iso_en && att) begin
        check(btdi, 8'h01);
        check(ptdo, s_ctdo);
      end else begin
        check(btdi, s_ctdo);
        check(ptdo, s_btdo);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {phr, psr, pscr, bhr, bsr, bscr} = 6'h3F;
    {iso_en, run, att, tms_b, tdi_b} = 5'h03;
    seed = 32'h3923;
    repeat (16) @(posedge clk);
    check({hr, sr, scr, isol}, {RST_HARD_N, RST_SOFT_N, RST_SCAN_N, RST_ISOLATED});
    rstn <= 1'b1;
    // every combination of probe and board reset requests
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      {phr, psr, pscr, bhr, bsr, bscr} <= 6'(i);
      repeat (4) @(posedge clk);
      #1;
      check(hr, 8'((i >> 5) & (i >> 2) & 1));
      check(sr, 8'((i >> 4) & (i >> 1) & 1));
      check(scr, 8'((i >> 3) & i & 1));
    end
    $display("reset merge test done");
    // no probe: board pulldown holds probe scan reset low
    @(posedge clk);
    {att, pscr, bscr} <= 3'h1;
    repeat (4) @(posedge clk);
    #1;
    check(scr, 8'h00);
    // strap and presence in every combination, with a random scan frame each
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {iso_en, att} <= 2'(k);
      repeat (4) @(posedge clk);
      #1;
      check(isol, 8'(k == 3));
      edge0 = edges;
      run <= 1'b1;
      repeat (20) begin
        @(posedge clk);
        seed = xs(seed);
        tdi_b <= seed[0];
        tms_b <= seed[1];
      end
      run <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("isolation and scan test done");
    finish_test();
  end
endmodule
